// file: sync_clock_prescaler.sv
// What this block does
// - separate divider fields for four clocks
// - high-speed bus clock follows processor clock
// - after reset all clocks run undivided
// - one shared 8-bit prescaler feeds all
// - any tap or undivided; cpu not slower (not enforced here: any field value is taken)
// - select writes accepted while peripherals run
// - one write changes all clocks together
// - same field value keeps that clock unchanged
// - ready flag reads 0 until change effective
// - ready enable raises interrupt on completion
// - bus read stalls until pending writes done
// - idle sleep stops only processor clock
// - wake runs handler, then resumes after sleep
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "sync_clock_prescaler_params.svh"
module sync_clock_prescaler
  import sync_clock_prescaler_pkg::*;
#(
  parameter int PRESCALER_W = `PRESCALER_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic sleep_request,
  input wire logic wake_event,
  input wire logic pb_write_pending,
  input wire logic pb_read_request,
  output logic pb_read_stall,
  output logic cpu_clk_en,
  output logic hsb_clk_en,
  output logic pba_clk_en,
  output logic pbb_clk_en,
  output logic cpu_resume,
  output logic pm_irq
);
  logic [31:0] clock_select_register_q;
  logic [31:0] pending_sel_q;
  logic [31:0] active_sel_q;
  logic [PRESCALER_W-1:0] prescaler_q;
  switch_state_t sw_q;
  logic [`IRQ_W-1:0] int_status_q;
  logic [`IRQ_W-1:0] int_mask_q;
  logic [`SLEEP_MODE_W-1:0] sleep_mode_q;
  sleep_state_t sl_q;
  logic [`IRQ_W-1:0] int_set;
  logic cpu_en_raw;
  logic hsb_en_raw;
  logic pba_en_raw;
  logic pbb_en_raw;
  logic clock_select_write;
  logic aligned;
  logic clock_ready_flag;
  logic cpu_run;
  logic bus_run;
  logic irq_pending;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // one clock's divider enable and tap out of a select word
  function automatic logic div_on(input logic [31:0] sel, input int lsb);
    div_on = sel[lsb+`SEL_DIV_BIT];
  endfunction : div_on

  function automatic logic [`SEL_TAP_W-1:0] div_tap(input logic [31:0] sel, input int lsb);
    div_tap = sel[lsb+:`SEL_TAP_W];
  endfunction : div_tap

  assign clock_select_write = reg_write && hit(reg_addr, `OFS_CLOCK_SELECT);
  // all-ones prescaler ends a period of every tap at once
  assign aligned = (prescaler_q == {PRESCALER_W{1'b1}});
  assign clock_ready_flag = (sw_q == SW_IDLE);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prescaler_q <= '0;
    end else begin
      prescaler_q <= prescaler_q + {{(PRESCALER_W-1){1'b0}}, 1'b1};
    end
  end

  // readback holds the last write even when it was refused
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clock_select_register_q <= `CLOCK_SELECT_RESET;
    end else if (clock_select_write) begin
      clock_select_register_q <= reg_wdata;
    end
  end

  // a rewrite while busy is ignored: the pending value stays whole
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sw_q <= SW_IDLE;
      pending_sel_q <= `CLOCK_SELECT_RESET;
      active_sel_q <= `CLOCK_SELECT_RESET;
    end else begin
      case (sw_q)
        SW_IDLE: begin
          if (clock_select_write) begin
            pending_sel_q <= reg_wdata;
            sw_q <= SW_WAIT_ALIGN;
          end
        end
        SW_WAIT_ALIGN: begin
          if (aligned) begin
            active_sel_q <= pending_sel_q;
            sw_q <= SW_APPLY;
          end
        end
        // a write landing here is dropped; software must wait for ready
        SW_APPLY: begin
          sw_q <= SW_IDLE;
        end
        default: begin
          sw_q <= SW_IDLE;
        end
      endcase
    end
  end

  clock_tap_gen #(.PRESCALER_W(PRESCALER_W)) u_cpu (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .prescaler_q(prescaler_q),
    .divider_enable_field(div_on(active_sel_q, `SEL_CPU_LSB)),
    .divider_tap_field(div_tap(active_sel_q, `SEL_CPU_LSB)),
    .clk_enable(cpu_en_raw)
  );

  // hsb field kept in the register but the clock follows the cpu
  assign hsb_en_raw = cpu_en_raw;

  clock_tap_gen #(.PRESCALER_W(PRESCALER_W)) u_pba (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .prescaler_q(prescaler_q),
    .divider_enable_field(div_on(active_sel_q, `SEL_PBA_LSB)),
    .divider_tap_field(div_tap(active_sel_q, `SEL_PBA_LSB)),
    .clk_enable(pba_en_raw)
  );

  clock_tap_gen #(.PRESCALER_W(PRESCALER_W)) u_pbb (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .prescaler_q(prescaler_q),
    .divider_enable_field(div_on(active_sel_q, `SEL_PBB_LSB)),
    .divider_tap_field(div_tap(active_sel_q, `SEL_PBB_LSB)),
    .clk_enable(pbb_en_raw)
  );

  // sleep sequencing; deep modes wait for the peripheral bus to drain
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sleep_mode_q <= `SLEEP_IDLE;
    end else if (reg_write && hit(reg_addr, `OFS_SLEEP_CTRL)) begin
      sleep_mode_q <= reg_wdata[`SLEEP_MODE_LSB+:`SLEEP_MODE_W];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sl_q <= SL_RUN;
    end else begin
      case (sl_q)
        SL_RUN: begin
          if (sleep_request) begin
            sl_q <= (sleep_mode_q == `SLEEP_IDLE) ? SL_SLEEP : SL_DRAIN;
          end
        end
        SL_DRAIN: begin
          if (!pb_write_pending) begin
            sl_q <= SL_SLEEP;
          end
        end
        SL_SLEEP: begin
          if (wake_event) begin
            sl_q <= SL_WAKE;
          end
        end
        SL_WAKE: begin
          sl_q <= SL_RUN;
        end
        default: begin
          sl_q <= SL_RUN;
        end
      endcase
    end
  end

  assign pb_read_stall = pb_read_request && pb_write_pending;

  // idle keeps the buses clocked; deeper modes stop every clock
  assign cpu_run = (sl_q == SL_RUN) || (sl_q == SL_WAKE);
  assign bus_run = (sl_q != SL_SLEEP) || (sleep_mode_q == `SLEEP_IDLE);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b1;
    end else begin
      cpu_clk_en <= cpu_en_raw && cpu_run;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hsb_clk_en <= 1'b1;
    end else begin
      hsb_clk_en <= hsb_en_raw && bus_run;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pba_clk_en <= 1'b1;
    end else begin
      pba_clk_en <= pba_en_raw && bus_run;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pbb_clk_en <= 1'b1;
    end else begin
      pbb_clk_en <= pbb_en_raw && bus_run;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cpu_resume <= 1'b0;
    end else begin
      // wake status sets a cycle early; pm_irq and resume rise in the same cycle
      cpu_resume <= (sl_q == SL_WAKE);
    end
  end

  // interrupt: set wins over clear
  always_comb begin
    int_set = '0;
    int_set[`IRQ_CLOCK_READY] = (sw_q == SW_APPLY);
    int_set[`IRQ_WAKE] = (sl_q == SL_SLEEP) && wake_event;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_status_q <= '0;
    end else if (reg_write && hit(reg_addr, `OFS_INT_CLEAR)) begin
      int_status_q <= (int_status_q & ~reg_wdata[`IRQ_W-1:0]) | int_set;
    end else begin
      int_status_q <= int_status_q | int_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_mask_q <= '0;
    end else if (reg_write && hit(reg_addr, `OFS_INT_ENABLE)) begin
      int_mask_q <= int_mask_q | reg_wdata[`IRQ_W-1:0];
    end else if (reg_write && hit(reg_addr, `OFS_INT_DISABLE)) begin
      int_mask_q <= int_mask_q & ~reg_wdata[`IRQ_W-1:0];
    end
  end

  assign irq_pending = |(int_status_q & int_mask_q);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pm_irq <= 1'b0;
    end else begin
      pm_irq <= irq_pending;
    end
  end

  // ready is live state in the status read, not a sticky bit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (!reg_read) begin
      reg_rdata <= '0;
    end else if (hit(reg_addr, `OFS_CLOCK_SELECT)) begin
      reg_rdata <= clock_select_register_q;
    end else if (hit(reg_addr, `OFS_INT_MASK)) begin
      reg_rdata <= {30'h0, int_mask_q};
    end else if (hit(reg_addr, `OFS_INT_STATUS)) begin
      reg_rdata <= {30'h0, int_status_q[`IRQ_WAKE], clock_ready_flag};
    end else if (hit(reg_addr, `OFS_SLEEP_CTRL)) begin
      reg_rdata <= {29'h0, sleep_mode_q};
    end else if (hit(reg_addr, `OFS_SLEEP_STATUS)) begin
      reg_rdata <= {30'h0, sl_q};
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : sync_clock_prescaler
`default_nettype wire

// file: sync_clock_prescaler_params.svh
`ifndef SYNC_CLOCK_PRESCALER_PARAMS_SVH
`define SYNC_CLOCK_PRESCALER_PARAMS_SVH

// register offsets
`define OFS_CLOCK_SELECT 8'h00
`define OFS_INT_ENABLE 8'h04
`define OFS_INT_DISABLE 8'h08
`define OFS_INT_MASK 8'h0C
`define OFS_INT_STATUS 8'h10
`define OFS_INT_CLEAR 8'h14
`define OFS_SLEEP_CTRL 8'h18
`define OFS_SLEEP_STATUS 8'h1C

// clock select field layout: enable bit then three tap bits per clock
`define SEL_CPU_LSB 0
`define SEL_HSB_LSB 8
`define SEL_PBA_LSB 16
`define SEL_PBB_LSB 24
`define SEL_DIV_BIT 7
`define SEL_TAP_W 3
`define CLOCK_SELECT_RESET 32'h0000_0000

// interrupt status bit positions
`define IRQ_CLOCK_READY 0
`define IRQ_WAKE 1
`define IRQ_W 2

// sleep control layout
`define SLEEP_MODE_LSB 0
`define SLEEP_MODE_W 3
`define SLEEP_IDLE 3'h0

`define PRESCALER_W 8

`endif

// file: sync_clock_prescaler_pkg.sv
package sync_clock_prescaler_pkg;
  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT_ALIGN,
    SW_APPLY
  } switch_state_t;

  typedef enum logic [1:0] {
    SL_RUN,
    SL_DRAIN,
    SL_SLEEP,
    SL_WAKE
  } sleep_state_t;
endpackage : sync_clock_prescaler_pkg

// file: clock_tap_gen.sv
`timescale 1ns/10ps
`default_nettype none
// one synchronous clock: a one-cycle enable pulse per divided period
module clock_tap_gen #(
  parameter int PRESCALER_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [PRESCALER_W-1:0] prescaler_q,
  input wire logic divider_enable_field,
  input wire logic [2:0] divider_tap_field,
  output logic clk_enable
);
  logic [PRESCALER_W:0] next_cnt;
  logic tick;

  // tap n toggles at 2^(n+1) divide; pulse when the low n+1 bits wrap
  always_comb begin
    next_cnt = {1'b0, prescaler_q} + {{PRESCALER_W{1'b0}}, 1'b1};
    tick = (next_cnt[divider_tap_field] == 1'b0)
      && (prescaler_q[divider_tap_field] == 1'b1);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clk_enable <= 1'b1;
    end else if (!divider_enable_field) begin
      clk_enable <= 1'b1;
    end else begin
      clk_enable <= tick;
    end
  end
endmodule : clock_tap_gen
`default_nettype wire

// file: pb_write_model.sv
`timescale 1ns/10ps
`default_nettype none
// peripheral bus side: a posted write drains over three bus clock pulses
module pb_write_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pba_clk_en,
  input wire logic post_write,
  output logic pb_write_pending
);
  logic [1:0] left_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      left_q <= 2'h0;
    end else if (post_write) begin
      // new transfers only when the bench posts one, never in sleep
      left_q <= 2'h3;
    end else if (pba_clk_en && left_q != 2'h0) begin
      left_q <= left_q - 2'h1;
    end
  end
  assign pb_write_pending = (left_q != 2'h0);
endmodule : pb_write_model
`default_nettype wire

// file: sync_clock_prescaler_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "sync_clock_prescaler_params.svh"
module scp_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic pb_write_pending,
  input wire logic pb_read_request,
  input wire logic pb_read_stall,
  input wire logic cpu_clk_en,
  input wire logic hsb_clk_en,
  input wire logic pba_clk_en,
  input wire logic pbb_clk_en,
  input wire logic cpu_resume,
  input wire logic pm_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence sel_write;
    reg_write && reg_addr == `OFS_CLOCK_SELECT;
  endsequence
  sequence status_read;
    reg_read && reg_addr == `OFS_INT_STATUS;
  endsequence
  a_stall_exact: assert property (
    pb_read_stall == (pb_read_request && pb_write_pending)) else $error("stall mismatch");
  a_ready_drops: assert property (
    sel_write ##[1:2] status_read |=> !reg_rdata[0]) else $error("ready set too early");
  a_rdata_quiet: assert property (
    !$past(reg_read) |-> reg_rdata == 32'h0) else $error("read data without read");
  a_hsb_with_cpu: assert property (
    cpu_clk_en |-> hsb_clk_en) else $error("bus clock missing beside cpu clock");
  a_reset_undivided: assert property (
    $rose(rst_n) |-> cpu_clk_en && hsb_clk_en && pba_clk_en && pbb_clk_en)
    else $error("clocks divided after reset");
  a_resume_single: assert property (
    cpu_resume |=> !cpu_resume) else $error("resume longer than one cycle");
  a_resume_runs: assert property (
    cpu_resume |-> ##[0:260] cpu_clk_en) else $error("cpu clock idle after resume");
  a_irq_holds: assert property (
    pm_irq && !reg_write && !$past(reg_write) |=> pm_irq) else $error("irq dropped alone");
endmodule : scp_properties
`default_nettype wire
bind sync_clock_prescaler scp_properties u_props (.*);

// file: sync_clock_prescaler_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sync_clock_prescaler_params.svh"
module sync_clock_prescaler_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic sleep_request = 1'b0;
  logic wake_event = 1'b0;
  logic pb_read_request = 1'b0;
  logic post_write = 1'b0;
  logic [31:0] reg_rdata, d, c;
  logic pb_write_pending, pb_read_stall, cpu_clk_en, hsb_clk_en;
  logic pba_clk_en, pbb_clk_en, cpu_resume, pm_irq;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  always #4 clk_sys = ~clk_sys;
  sync_clock_prescaler dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sleep_request(sleep_request), .wake_event(wake_event),
    .pb_write_pending(pb_write_pending), .pb_read_request(pb_read_request),
    .pb_read_stall(pb_read_stall), .cpu_clk_en(cpu_clk_en), .hsb_clk_en(hsb_clk_en),
    .pba_clk_en(pba_clk_en), .pbb_clk_en(pbb_clk_en), .cpu_resume(cpu_resume),
    .pm_irq(pm_irq));
  pb_write_model u_pb (.clk_sys(clk_sys), .rst_n(rst_n), .pba_clk_en(pba_clk_en),
    .post_write(post_write), .pb_write_pending(pb_write_pending));
  task conclude;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  // hang guard: all tests need well under 2000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // per-byte pulse counts: {pbb, pba, hsb, cpu}
  task count_en(input int n);
    c = 32'h0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      c = c + {7'h0, pbb_clk_en, 7'h0, pba_clk_en, 7'h0, hsb_clk_en, 7'h0, cpu_clk_en};
    end
  endtask : count_en
  task test_reset;
    rd(`OFS_INT_STATUS);
    chk(d & 32'h1, 32'h1);
    rd(`OFS_CLOCK_SELECT);
    chk(d, `CLOCK_SELECT_RESET);
    rd(8'hF0);
    chk(d, 32'h0);
    count_en(8);
    chk(c, 32'h0808_0808);
    $display("test reset done");
  endtask : test_reset
  task test_scale;
    int i;
    wr(`OFS_INT_ENABLE, 32'h1);
    // cpu /2, pba /4, pbb rewritten unchanged while buses run
    wr(`OFS_CLOCK_SELECT, 32'h0081_0080);
    rd(`OFS_INT_STATUS);
    chk(d & 32'h1, 32'h0);
    for (i = 0; i < 300 && pm_irq !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({31'h0, pm_irq}, 32'h1);
    rd(`OFS_INT_STATUS);
    chk(d & 32'h1, 32'h1);
    count_en(16);
    chk(c, 32'h1004_0808);
    wr(`OFS_INT_CLEAR, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, pm_irq}, 32'h0);
    $display("test scale done");
  endtask : test_scale
  task test_masked;
    wr(`OFS_INT_DISABLE, 32'h1);
    // ready was seen in the previous test before this rewrite
    wr(`OFS_CLOCK_SELECT, 32'h0);
    repeat (300) @(posedge clk_sys);
    chk({31'h0, pm_irq}, 32'h0);
    count_en(8);
    chk(c, 32'h0808_0808);
    $display("test masked done");
  endtask : test_masked
  task test_stall;
    int i;
    @(posedge clk_sys);
    post_write <= 1'b1;
    @(posedge clk_sys);
    post_write <= 1'b0;
    pb_read_request <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({31'h0, pb_read_stall}, 32'h1);
    for (i = 0; i < 50 && pb_write_pending !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({31'h0, pb_read_stall}, 32'h0);
    @(posedge clk_sys);
    pb_read_request <= 1'b0;
    $display("test stall done");
  endtask : test_stall
  task test_sleep;
    int i;
    wr(`OFS_SLEEP_CTRL, {29'h0, `SLEEP_IDLE});
    @(posedge clk_sys);
    sleep_request <= 1'b1;
    @(posedge clk_sys);
    sleep_request <= 1'b0;
    repeat (4) @(posedge clk_sys);
    count_en(8);
    chk(c, 32'h0808_0800);
    @(posedge clk_sys);
    wake_event <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
    for (i = 0; i < 20 && cpu_resume !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({31'h0, cpu_resume}, 32'h1);
    repeat (4) @(posedge clk_sys);
    count_en(8);
    chk(c, 32'h0808_0808);
    rd(`OFS_INT_STATUS);
    chk(d & 32'h2, 32'h2);
    wr(`OFS_INT_CLEAR, 32'h2);
    rd(`OFS_INT_STATUS);
    chk(d & 32'h2, 32'h0);
    $display("test sleep done");
  endtask : test_sleep
  // deep sleep: the cpu clock stops on entering drain, the bus clocks only after the posted write has drained
  task test_deep;
    int i;
    wr(`OFS_INT_ENABLE, 32'h2);
    wr(`OFS_SLEEP_CTRL, 32'h1);
    rd(`OFS_SLEEP_CTRL);
    chk(d, 32'h1);
    @(posedge clk_sys);
    post_write <= 1'b1;
    @(posedge clk_sys);
    post_write <= 1'b0;
    sleep_request <= 1'b1;
    @(posedge clk_sys);
    sleep_request <= 1'b0;
    rd(`OFS_SLEEP_STATUS);
    chk(d, {30'h0, sync_clock_prescaler_pkg::SL_DRAIN});
    repeat (6) @(posedge clk_sys);
    count_en(8);
    chk(c, 32'h0);
    chk({31'h0, pm_irq}, 32'h0);
    @(posedge clk_sys);
    wake_event <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
    for (i = 0; i < 20 && cpu_resume !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({30'h0, pm_irq, cpu_resume}, 32'h3);
    rd(`OFS_INT_MASK);
    chk(d, 32'h2);
    wr(`OFS_INT_CLEAR, 32'h2);
    wr(`OFS_INT_DISABLE, 32'h2);
    repeat (3) @(posedge clk_sys);
    count_en(8);
    chk(c, 32'h0808_0808);
    chk({31'h0, pm_irq}, 32'h0);
    $display("test deep done");
  endtask : test_deep
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_reset();
    test_scale();
    test_masked();
    test_stall();
    test_sleep();
    test_deep();
    conclude();
  end
endmodule : sync_clock_prescaler_tb
`default_nettype wire
